// *** byte_alu.sv ***
// Purpose: Combinational byte operations with their flag effects
// Assumes: Flags in is the current flag register
// Notes: Undefined half carry is left at its old value
`timescale 1ns/1ps
module byte_alu
  import exec_pkg::*;
(
  input wire op_e op_i,
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic [7:0] flags_i,
  output logic [7:0] result_o,
  output logic [7:0] flags_o
);

  logic [8:0] diff;

  always_comb begin
    result_o = a_i;
    flags_o = flags_i;
    diff = 9'h000 - {1'b0, a_i};
    case (op_i)
      OP_SHIFT_LEFT: begin
        result_o = {a_i[6:0], 1'b0};
        flags_o[FLAG_C] = a_i[7];
        flags_o[FLAG_V] = a_i[7] ^ a_i[6];
        flags_o[FLAG_N] = a_i[6];
        flags_o[FLAG_Z] = (a_i[6:0] == 7'h00);
      end
      OP_SHIFT_RIGHT: begin
        result_o = {1'b0, a_i[7:1]};
        flags_o[FLAG_C] = a_i[0];
        flags_o[FLAG_N] = 1'b0;
        flags_o[FLAG_Z] = (a_i[7:1] == 7'h00);
      end
      OP_COMPLEMENT: begin
        result_o = diff[7:0];
        flags_o[FLAG_C] = (a_i != NEG_ZERO_OPERAND);
        flags_o[FLAG_V] = (a_i == NEG_OVF_OPERAND);
        flags_o[FLAG_N] = diff[7];
        flags_o[FLAG_Z] = (diff[7:0] == 8'h00);
      end
      OP_ACC_MERGE: begin
        result_o = a_i | b_i;
        flags_o[FLAG_N] = result_o[7];
        flags_o[FLAG_Z] = (result_o == 8'h00);
        flags_o[FLAG_V] = 1'b0;
      end
      default: begin
        result_o = a_i;
        flags_o = flags_i;
      end
    endcase
  end

endmodule

// *** byte_mem_model.sv ***
// Purpose: Byte memory holding operands and both stacks
// Assumes: Read data is valid only in the cycle after the read request
// Notes: Outside that cycle the data lines toggle so a late sample is caught
`timescale 1ns/1ps
module byte_mem_model
  import exec_pkg::*;
(
  input wire logic clk_sys_i,
  input wire mem_cmd_s cmd_i,
  output logic [7:0] rdata_o
);
  logic [7:0] bytes [0:65535];
  int writes = 0;
  initial rdata_o = 8'ha5;
  always @(posedge clk_sys_i) begin
    if (cmd_i.req && cmd_i.wr) begin
      bytes[cmd_i.addr] <= cmd_i.wdata;
      writes <= writes + 1;
    end
    if (cmd_i.req && !cmd_i.wr) begin
      rdata_o <= bytes[cmd_i.addr];
    end else begin
      rdata_o <= ~rdata_o;
    end
  end
endmodule

// *** exec_assertions.sv ***
// Purpose: Port-level checks for the shift, multiply, negate and stack block
// Assumes: Register results are visible in the cycle that done_o is high
// Notes: Results are judged against a snapshot taken when the op is accepted
`timescale 1ns/1ps
module exec_assertions
  import exec_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire request_s req_i,
  input wire logic [7:0] mem_rdata_i,
  input wire mem_cmd_s mem_o,
  input wire regs_s regs_o,
  input wire logic busy_o,
  input wire logic done_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  regs_s sr;
  request_s sq;
  logic [7:0] f;
  assign f = regs_o.flags;
  // Snapshot only on accept, so a refused start cannot disturb the reference
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sr <= '0;
      sq <= '0;
    end else if (start_i && !busy_o) begin
      sr <= regs_o;
      sq <= req_i;
    end
  end
  property p_shift_left;
    done_o && sq.op == OP_SHIFT_LEFT && sq.target == TGT_ACC1 |-> regs_o.acc1 ==
      {sr.acc1[6:0], 1'b0} && f[FLAG_C] == sr.acc1[7] && f[FLAG_N] == sr.acc1[6]
      && f[FLAG_V] == (sr.acc1[7] ^ sr.acc1[6]);
  endproperty
  a_shift_left: assert property (p_shift_left)
    else $error("left shift result or flags wrong");
  property p_shift_right;
    done_o && sq.op == OP_SHIFT_RIGHT && sq.target == TGT_ACC2 |-> regs_o.acc2 ==
      {1'b0, sr.acc2[7:1]} && f[FLAG_C] == sr.acc2[0] && !f[FLAG_N]
      && f[FLAG_V] == sr.flags[FLAG_V] && f[FLAG_H] == sr.flags[FLAG_H];
  endproperty
  a_shift_right: assert property (p_shift_right)
    else $error("right shift result or flags wrong");
  property p_product;
    done_o && sq.op == OP_PRODUCT |-> {regs_o.acc1, regs_o.acc2} == sr.acc1 * sr.acc2
      && f[FLAG_C] == regs_o.acc2[7] && f[FLAG_N] == sr.flags[FLAG_N];
  endproperty
  a_product: assert property (p_product)
    else $error("product or its flags wrong");
  property p_negate;
    done_o && sq.op == OP_COMPLEMENT && sq.target == TGT_ACC1 |-> regs_o.acc1 ==
      8'h00 - sr.acc1 && f[FLAG_C] == (sr.acc1 != 8'h00) && f[FLAG_V] == (sr.acc1 == 8'h80);
  endproperty
  a_negate: assert property (p_negate)
    else $error("negate result or flags wrong");
  property p_merge;
    done_o && sq.op == OP_ACC_MERGE && sq.target == TGT_ACC2 |-> regs_o.acc2 ==
      (sr.acc2 | sq.operand) && !f[FLAG_V] && f[FLAG_C] == sr.flags[FLAG_C];
  endproperty
  a_merge: assert property (p_merge)
    else $error("accumulator merge wrong");
  property p_flag_set;
    done_o && sq.op == OP_FLAG_SET |-> f == (sr.flags | sq.operand);
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag set immediate wrong");
  property p_idle;
    done_o && sq.op == OP_IDLE |-> regs_o.pc == sr.pc + 16'h1 && regs_o[95:0] == sr[95:0];
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle op changed more than the program counter");
  property p_push_flags;
    done_o && (sq.op == OP_SYS_PUSH || sq.op == OP_USR_PUSH) |-> f == sr.flags;
  endproperty
  a_push_flags: assert property (p_push_flags)
    else $error("push changed the flags");
  property p_push_order;
    mem_o.req && mem_o.wr ##1 mem_o.req && mem_o.wr |-> mem_o.addr == $past(mem_o.addr) - 16'h1;
  endproperty
  a_push_order: assert property (p_push_order)
    else $error("push bytes not at descending addresses");
  property p_pop_order;
    mem_o.req && !mem_o.wr ##3 mem_o.req && !mem_o.wr |->
      mem_o.addr == $past(mem_o.addr, 3) + 16'h1;
  endproperty
  a_pop_order: assert property (p_pop_order)
    else $error("pop bytes not at ascending addresses");
  c_pop: cover property (done_o && sq.op == OP_SYS_POP);
  c_product: cover property (done_o && sq.op == OP_PRODUCT);
  c_push: cover property (mem_o.req && mem_o.wr ##1 mem_o.req && mem_o.wr);
endmodule

bind shift_mul_negate_stack_exec exec_assertions chk (.clk_sys_i(clk_sys_i),
  .sys_rst_i(sys_rst_i), .start_i(start_i), .req_i(req_i), .mem_rdata_i(mem_rdata_i),
  .mem_o(mem_o), .regs_o(regs_o), .busy_o(busy_o), .done_o(done_o));

// *** exec_pkg.sv ***
// Purpose: Shared constants and types for the shift/multiply/stack execution block
// Assumes: 8-bit data, 16-bit addresses, byte-wide memory port
// Notes: Flag bit positions follow the flag register layout
package exec_pkg;

  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int FLAG_I = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_F = 6;
  localparam int FLAG_E = 7;

  localparam logic [7:0] FLAG_RESET = 8'h50;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] NEG_OVF_OPERAND = 8'h80;
  localparam logic [7:0] NEG_ZERO_OPERAND = 8'h00;

  // Postbyte bit positions of the stack transfer mask
  localparam int SEL_FLAGS = 0;
  localparam int SEL_ACC1 = 1;
  localparam int SEL_ACC2 = 2;
  localparam int SEL_PAGE = 3;
  localparam int SEL_XIDX = 4;
  localparam int SEL_YIDX = 5;
  localparam int SEL_OTHER_SP = 6;
  localparam int SEL_PC = 7;

  typedef enum logic [3:0] {
    OP_IDLE = 4'h0,
    OP_SHIFT_LEFT = 4'h1,
    OP_SHIFT_RIGHT = 4'h2,
    OP_PRODUCT = 4'h3,
    OP_COMPLEMENT = 4'h4,
    OP_ACC_MERGE = 4'h5,
    OP_FLAG_SET = 4'h6,
    OP_SYS_PUSH = 4'h7,
    OP_USR_PUSH = 4'h8,
    OP_SYS_POP = 4'h9,
    OP_USR_POP = 4'ha
  } op_e;

  // Operand location for the byte operations
  typedef enum logic [1:0] {
    TGT_ACC1 = 2'b00,
    TGT_ACC2 = 2'b01,
    TGT_MEM = 2'b10
  } target_e;

  typedef struct packed {
    op_e op;
    target_e target;
    logic [7:0] operand;
    logic [15:0] mem_addr;
  } request_s;

  typedef struct packed {
    logic req;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_cmd_s;

  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] sys_sp;
    logic [15:0] usr_sp;
    logic [15:0] x_idx;
    logic [15:0] y_idx;
    logic [7:0] page;
    logic [7:0] acc1;
    logic [7:0] acc2;
    logic [7:0] flags;
  } regs_s;

endpackage

// *** shift_mul_negate_stack_exec.sv ***
// What this block does
// - Left shift moves bits up one and forces bit zero to zero
// - Left shift puts old bit seven in carry, N and Z from result
// - Left shift loads overflow with old bit six xor bit seven
// - Arithmetic and logical left shift are one identical operation
// - Right shift inserts zero at top, bit zero to carry, N cleared
// - Multiply unsigned accumulators, high byte to first, low to second
// - Multiply sets Z on zero product, carry from low byte bit seven
// - Negate gives zero minus operand, carry is the borrow
// - Negate overflow only for 80, carry clear only for 00
// - Idle op advances only the program counter
// - Accumulator merge ORs byte in, N and Z from result, V cleared
// - Flag set ORs immediate into whole flag register, never clears
// - Postbyte bits pick PC, other SP, Y, X, page, acc2, acc1, flags
// - System push goes bit seven down, pre-decrement, low byte first
// - User push uses user pointer; bit six saves system pointer
// - System pop goes bit zero up, post-increment, high byte first
// - User pop uses user pointer; bit six reloads system pointer
// - Push leaves flags; pop changes flags only via bit zero
// - Any postbyte allowed, zero moves nothing; own pointer never moved
//
// Purpose: Executes one operation per start pulse against a byte memory
// Assumes: Memory answers a read in the cycle after the request
// Notes: Opcode fetch and addressing are done outside this block
`timescale 1ns/1ps
module shift_mul_negate_stack_exec
  import exec_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire request_s req_i,
  input wire logic [7:0] mem_rdata_i,
  output mem_cmd_s mem_o,
  output regs_s regs_o,
  output logic busy_o,
  output logic done_o
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_MEM_READ = 3'b001,
    ST_MEM_WRITE = 3'b010,
    ST_STACK = 3'b011,
    ST_POP_WAIT = 3'b100,
    ST_READ_WAIT = 3'b101
  } state_e;

  state_e state, next_state;
  regs_s regs, next_regs;
  mem_cmd_s mem, next_mem;
  request_s cur, next_cur;
  logic [7:0] mask, next_mask;
  logic hi_half, next_hi_half;
  logic busy, next_busy;
  logic done, next_done;

  logic [7:0] alu_a;
  logic [7:0] alu_res;
  logic [7:0] alu_flags;
  logic [15:0] product;
  logic [2:0] push_idx;
  logic [2:0] pop_idx;
  logic is_push;
  logic is_user;
  logic [15:0] sel_word;
  logic [15:0] sp_used;
  logic [7:0] pop_byte;

  // Widen first: a cast alone keeps the product at eight bits
  assign product = {8'h00, regs.acc1} * {8'h00, regs.acc2};

  byte_alu u_alu (
    .op_i(cur.op),
    .a_i(alu_a),
    .b_i(cur.operand),
    .flags_i(regs.flags),
    .result_o(alu_res),
    .flags_o(alu_flags)
  );

  // Highest set bit for pushes, lowest for pops
  always_comb begin
    push_idx = 3'd0;
    pop_idx = 3'd7;
    for (int i = 0; i < 8; i++) begin
      if (mask[i]) begin
        push_idx = 3'(i);
      end
    end
    for (int i = 7; i >= 0; i--) begin
      if (mask[i]) begin
        pop_idx = 3'(i);
      end
    end
  end

  always_comb begin
    is_push = (cur.op == OP_SYS_PUSH) || (cur.op == OP_USR_PUSH);
    is_user = (cur.op == OP_USR_PUSH) || (cur.op == OP_USR_POP);
    sp_used = is_user ? regs.usr_sp : regs.sys_sp;
    alu_a = (cur.target == TGT_ACC1) ? regs.acc1 :
            (cur.target == TGT_ACC2) ? regs.acc2 : cur.operand;
    // Word selected by the register now being pushed
    case (push_idx)
      3'd7: sel_word = regs.pc;
      3'd6: sel_word = is_user ? regs.sys_sp : regs.usr_sp;
      3'd5: sel_word = regs.y_idx;
      3'd4: sel_word = regs.x_idx;
      3'd3: sel_word = {8'h00, regs.page};
      3'd2: sel_word = {8'h00, regs.acc2};
      3'd1: sel_word = {8'h00, regs.acc1};
      default: sel_word = {8'h00, regs.flags};
    endcase
    pop_byte = mem_rdata_i;
  end

  always_comb begin
    next_state = state;
    next_regs = regs;
    next_mem = mem;
    next_cur = cur;
    next_mask = mask;
    next_hi_half = hi_half;
    next_busy = busy;
    next_done = 1'b0;
    case (state)
      ST_IDLE: begin
        next_mem.req = 1'b0;
        next_mem.wr = 1'b0;
        if (start_i) begin
          next_cur = req_i;
          next_mask = req_i.operand;
          next_hi_half = 1'b0;
          next_busy = 1'b1;
          next_state = ST_STACK;
          if (req_i.op == OP_SHIFT_LEFT || req_i.op == OP_SHIFT_RIGHT ||
              req_i.op == OP_COMPLEMENT) begin
            if (req_i.target == TGT_MEM) begin
              next_mem.req = 1'b1;
              next_mem.addr = req_i.mem_addr;
              next_state = ST_READ_WAIT;
            end
          end
        end
      end
      ST_READ_WAIT: begin
        // Read data stands only in the cycle after the request, so wait a cycle
        next_mem.req = 1'b0;
        if (cur.op == OP_SYS_POP || cur.op == OP_USR_POP) begin
          next_state = ST_POP_WAIT;
        end else begin
          next_state = ST_MEM_READ;
        end
      end
      ST_MEM_READ: begin
        // Memory byte arrives now; reuse the operand slot for it
        next_mem.req = 1'b0;
        next_cur.operand = mem_rdata_i;
        next_state = ST_MEM_WRITE;
      end
      ST_MEM_WRITE: begin
        next_mem.req = 1'b1;
        next_mem.wr = 1'b1;
        next_mem.wdata = alu_res;
        next_regs.flags = alu_flags;
        next_cur.op = OP_IDLE;
        next_state = ST_POP_WAIT;
      end
      ST_POP_WAIT: begin
        next_mem.req = 1'b0;
        next_mem.wr = 1'b0;
        if (cur.op == OP_IDLE) begin
          next_busy = 1'b0;
          next_done = 1'b1;
          next_state = ST_IDLE;
        end else begin
          // Popped byte lands; pointer already stepped past it
          // hi_half low means this byte is the high byte of a word; the low byte is still to come
          case (pop_idx)
            3'd7: if (!hi_half) next_regs.pc[15:8] = pop_byte;
                  else next_regs.pc[7:0] = pop_byte;
            3'd6: if (is_user) begin
                    if (!hi_half) next_regs.sys_sp[15:8] = pop_byte;
                    else next_regs.sys_sp[7:0] = pop_byte;
                  end else begin
                    if (!hi_half) next_regs.usr_sp[15:8] = pop_byte;
                    else next_regs.usr_sp[7:0] = pop_byte;
                  end
            3'd5: if (!hi_half) next_regs.y_idx[15:8] = pop_byte;
                  else next_regs.y_idx[7:0] = pop_byte;
            3'd4: if (!hi_half) next_regs.x_idx[15:8] = pop_byte;
                  else next_regs.x_idx[7:0] = pop_byte;
            3'd3: next_regs.page = pop_byte;
            3'd2: next_regs.acc2 = pop_byte;
            3'd1: next_regs.acc1 = pop_byte;
            default: next_regs.flags = pop_byte;
          endcase
          if (pop_idx >= 3'd4 && !hi_half) begin
            next_hi_half = 1'b1;
          end else begin
            next_hi_half = 1'b0;
            next_mask[pop_idx] = 1'b0;
          end
          next_state = ST_STACK;
        end
      end
      ST_STACK: begin
        next_mem.req = 1'b0;
        next_mem.wr = 1'b0;
        case (cur.op)
          OP_SYS_PUSH, OP_USR_PUSH, OP_SYS_POP, OP_USR_POP: begin
            if (mask == 8'h00) begin
              next_busy = 1'b0;
              next_done = 1'b1;
              next_state = ST_IDLE;
            end else if (is_push) begin
              // Pre-decrement, low byte first
              next_mem.req = 1'b1;
              next_mem.wr = 1'b1;
              next_mem.addr = 16'(sp_used - 16'h0001);
              next_mem.wdata = (push_idx >= 3'd4 && hi_half) ? sel_word[15:8] :
                               sel_word[7:0];
              if (is_user) next_regs.usr_sp = 16'(sp_used - 16'h0001);
              else next_regs.sys_sp = 16'(sp_used - 16'h0001);
              if (push_idx >= 3'd4 && !hi_half) begin
                next_hi_half = 1'b1;
              end else begin
                next_hi_half = 1'b0;
                next_mask[push_idx] = 1'b0;
              end
            end else begin
              // Read then post-increment, high byte first
              next_mem.req = 1'b1;
              next_mem.addr = sp_used;
              if (is_user) next_regs.usr_sp = 16'(sp_used + 16'h0001);
              else next_regs.sys_sp = 16'(sp_used + 16'h0001);
              next_state = ST_READ_WAIT;
            end
          end
          OP_PRODUCT: begin
            next_regs.acc1 = product[15:8];
            next_regs.acc2 = product[7:0];
            next_regs.flags[FLAG_Z] = (product == 16'h0000);
            next_regs.flags[FLAG_C] = product[7];
          end
          OP_FLAG_SET: begin
            next_regs.flags = regs.flags | cur.operand;
          end
          OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_COMPLEMENT, OP_ACC_MERGE: begin
            next_regs.flags = alu_flags;
            if (cur.target == TGT_ACC2) next_regs.acc2 = alu_res;
            else next_regs.acc1 = alu_res;
          end
          default: begin
          end
        endcase
        if (!(cur.op inside {OP_SYS_PUSH, OP_USR_PUSH, OP_SYS_POP, OP_USR_POP})) begin
          next_regs.pc = 16'(regs.pc + 16'h0001);
          next_busy = 1'b0;
          next_done = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= ST_IDLE;
      regs <= '{WORD_RESET, WORD_RESET, WORD_RESET, WORD_RESET, WORD_RESET,
                BYTE_RESET, BYTE_RESET, BYTE_RESET, FLAG_RESET};
      mem <= '0;
      cur <= '0;
      mask <= 8'h00;
      hi_half <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      regs <= next_regs;
      mem <= next_mem;
      cur <= next_cur;
      mask <= next_mask;
      hi_half <= next_hi_half;
      busy <= next_busy;
      done <= next_done;
    end
  end

  assign mem_o = mem;
  assign regs_o = regs;
  assign busy_o = busy;
  assign done_o = done;

endmodule

// *** tb.sv ***
// Purpose: Self-checking bench driving one op at a time against the memory model
// Assumes: Inputs change at the falling edge; results read in the done cycle
// Notes: Registers are preset by popping known bytes, not by peeking
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module tb;
  import exec_pkg::*;
  logic clk_sys_i, sys_rst_i, start_i, busy_o, done_o;
  request_s req_i;
  logic [7:0] mem_rdata_i;
  mem_cmd_s mem_o;
  regs_s regs_o;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [15:0] sp;
  shift_mul_negate_stack_exec uut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .start_i(start_i), .req_i(req_i), .mem_rdata_i(mem_rdata_i), .mem_o(mem_o),
    .regs_o(regs_o), .busy_o(busy_o), .done_o(done_o));
  byte_mem_model mem (.clk_sys_i(clk_sys_i), .cmd_i(mem_o), .rdata_o(mem_rdata_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  task automatic give_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic run(op_e op, target_e tg, logic [7:0] opd, logic [15:0] ad);
    int n;
    @(negedge clk_sys_i);
    req_i = '{op, tg, opd, ad};
    start_i = 1'b1;
    @(negedge clk_sys_i);
    start_i = 1'b0;
    for (n = 0; n < 200 && done_o !== 1'b1; n++) begin
      @(negedge clk_sys_i);
    end
    `CHK("done seen", 1'b1, done_o)
  endtask
  task automatic load(logic [7:0] f, logic [7:0] a, logic [7:0] b);
    mem.bytes[sp] = f;
    mem.bytes[sp + 16'h1] = a;
    mem.bytes[sp + 16'h2] = b;
    run(OP_SYS_POP, TGT_ACC1, 8'h07, 16'h0);
    sp = sp + 16'h3;
    `CHK("pop", {f, a, b, sp}, {regs_o.flags, regs_o.acc1, regs_o.acc2, regs_o.sys_sp})
  endtask
  function automatic logic [15:0] model(op_e op, logic [7:0] a, logic [7:0] o, logic [7:0] f);
    logic [7:0] r;
    r = a;
    case (op)
      OP_SHIFT_LEFT: begin
        r = {a[6:0], 1'b0};
        f[FLAG_C] = a[7];
        f[FLAG_V] = a[7] ^ a[6];
      end
      OP_SHIFT_RIGHT: begin
        r = {1'b0, a[7:1]};
        f[FLAG_C] = a[0];
      end
      OP_COMPLEMENT: begin
        r = 8'h00 - a;
        f[FLAG_C] = (a != 8'h00);
        f[FLAG_V] = (a == 8'h80);
      end
      default: begin
        r = a | o;
        f[FLAG_V] = 1'b0;
      end
    endcase
    f[FLAG_N] = r[7];
    f[FLAG_Z] = (r == 8'h00);
    return {r, f};
  endfunction
  task automatic alu(op_e op, target_e tg, logic [7:0] a, logic [7:0] o, logic [7:0] f);
    logic [15:0] e;
    logic [7:0] got;
    mem.bytes[16'h4000] = a;
    load(f, a, a);
    e = model(op, a, o, f);
    run(op, tg, o, 16'h4000);
    got = (tg == TGT_MEM) ? mem.bytes[16'h4000] : (tg == TGT_ACC1) ? regs_o.acc1 : regs_o.acc2;
    `CHK("alu result", e[15:8], got)
    `CHK("alu flags", e[7:0], regs_o.flags)
  endtask
  task automatic mul(logic [7:0] a, logic [7:0] b, logic [7:0] f);
    logic [15:0] p;
    p = a * b;
    load(f, a, b);
    run(OP_PRODUCT, TGT_ACC1, 8'h00, 16'h0);
    f[FLAG_C] = p[7];
    f[FLAG_Z] = (p == 16'h0);
    `CHK("product", {p, f}, {regs_o.acc1, regs_o.acc2, regs_o.flags})
  endtask
  initial begin
    #(5 * 20000);
    n_mismatch++;
    $display("CHECK FAILED watchdog exp done got hang");
    give_verdict();
  end
  initial begin
    sys_rst_i = 1'b1;
    start_i = 1'b0;
    req_i = '0;
    sp = 16'h0;
    repeat (20) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    `CHK("reset regs", {104'h0, FLAG_RESET}, regs_o)
    $display("test reset done");
    for (int i = 0; i < 12; i++) mem.bytes[i] = 8'(i * 17);
    mem.bytes[0] = 8'h2b;
    run(OP_SYS_POP, TGT_ACC1, 8'hff, 16'h0);
    `CHK("full pop", {48'haabb000c8899, 40'h4455667733, 16'h1122, 8'h2b}, regs_o)
    run(OP_IDLE, TGT_ACC1, 8'h00, 16'h0);
    `CHK("idle", {48'haabc000c8899, 40'h4455667733, 16'h1122, 8'h2b}, regs_o)
    `CHK("idle writes", 0, mem.writes)
    run(OP_SYS_PUSH, TGT_ACC1, 8'h90, 16'h0);
    `CHK("push bytes", 32'h4455aabc, {mem.bytes[8], mem.bytes[9], mem.bytes[10], mem.bytes[11]})
    `CHK("push sp flags", {16'h0008, 8'h2b}, {regs_o.sys_sp, regs_o.flags})
    run(OP_USR_PUSH, TGT_ACC1, 8'h40, 16'h0);
    `CHK("user push", {24'h000888, 16'h8897}, {mem.bytes[16'h8897], mem.bytes[16'h8898], 8'h88, regs_o.usr_sp})
    run(OP_SYS_PUSH, TGT_ACC1, 8'h00, 16'h0);
    run(OP_SYS_POP, TGT_ACC1, 8'h00, 16'h0);
    `CHK("zero postbyte", {16'h0008, 32'd6}, {regs_o.sys_sp, mem.writes})
    mem.bytes[16'h8898] = 8'h40;
    run(OP_USR_POP, TGT_ACC1, 8'h40, 16'h0);
    `CHK("user pop", {32'h00408899, 8'h2b}, {regs_o.sys_sp, regs_o.usr_sp, regs_o.flags})
    sp = 16'h0040;
    $display("test stack done");
    alu(OP_SHIFT_LEFT, TGT_ACC1, 8'hc0, 8'h00, 8'h00);
    alu(OP_SHIFT_LEFT, TGT_ACC2, 8'h40, 8'h00, 8'h0f);
    alu(OP_SHIFT_LEFT, TGT_MEM, 8'h80, 8'h00, 8'h20);
    alu(OP_SHIFT_RIGHT, TGT_ACC2, 8'h81, 8'h00, 8'h2a);
    alu(OP_SHIFT_RIGHT, TGT_MEM, 8'h01, 8'h00, 8'h08);
    alu(OP_COMPLEMENT, TGT_ACC1, 8'h80, 8'h00, 8'h00);
    alu(OP_COMPLEMENT, TGT_ACC1, 8'h00, 8'h00, 8'h03);
    alu(OP_COMPLEMENT, TGT_MEM, 8'h01, 8'h00, 8'h00);
    alu(OP_ACC_MERGE, TGT_ACC1, 8'h0f, 8'hf0, 8'h03);
    alu(OP_ACC_MERGE, TGT_ACC2, 8'h00, 8'h00, 8'h0b);
    $display("test alu done");
    mul(8'hff, 8'hff, 8'h2a);
    mul(8'h0c, 8'h0b, 8'h00);
    mul(8'h00, 8'h05, 8'h09);
    $display("test product done");
    load(8'h00, 8'h00, 8'h00);
    run(OP_FLAG_SET, TGT_ACC1, 8'hd0, 16'h0);
    run(OP_FLAG_SET, TGT_ACC1, 8'h01, 16'h0);
    `CHK("flag set", 8'hd1, regs_o.flags)
    $display("test flag set done");
    give_verdict();
  end
endmodule
